// ===== verilog/sos_map.svh
// Constants for the standby release and oscillation stabilization block.
// Assumes inclusion by bare name from the package and the design modules.
//
// Function
// R01 - As each stabilization threshold passes, status bits set one after another from the first stage and stay set.
// R02 - The counter counts only up to the selected wait and only status bits up to that wait become set.
// R03 - Under the internal oscillator, software selects a wait at least as long as the status wait it polls for.
// R04 - The counted crystal wait starts only once oscillation has actually started.
// R05 - Under the crystal clock, software writes the time select before issuing the stop instruction.
// R06 - Software does not change the time select while a crystal wait is in progress.
// R07 - Any pending unmasked interrupt cancels standby at once, even at the moment of entry; the code does so for halt only, stop goes through the wait.
// R08 - A pending interrupt at stop turns stop into halt, and operation resumes when the selected wait has elapsed.
// R09 - Software should clear the converter start and enable bits before stop to save current.
// R10 - After stop, software restarts any peripheral that halted or lost its clock in stop.
// R11 - Stop is entered only from the main system clock; halt from either clock.
// R12 - Stop entry clears all status bits and resets the counter so counting restarts from zero.
`ifndef SOS_MAP_SVH
`define SOS_MAP_SVH

`define SOS_ADDR_W          4
`define SOS_ADDR_STATUS     4'h0
`define SOS_ADDR_SELECT     4'h1
`define SOS_ADDR_CONTROL    4'h2
`define SOS_STAGES          5
`define SOS_SEL_W           3
`define SOS_SEL_RESET       3'h4
`define SOS_CNT_W           20
// Stage k finishes at 2^(SOS_BASE_LOG2 + 2k) counts
`define SOS_BASE_LOG2       8
`define SOS_CTRL_STOP_BIT   0
`define SOS_CTRL_HALT_BIT   1

`endif

// ===== verilog/sos_pkg.sv
// Types for the standby release and oscillation stabilization block.
// Assumes sos_map.svh on the include path.
`include "sos_map.svh"
package sos_pkg;
  typedef enum logic [3:0] {
    SOS_RUN   = 4'b0001,
    SOS_HALT  = 4'b0010,
    SOS_STOP  = 4'b0100,
    SOS_WAIT  = 4'b1000
  } sos_state_e;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`SOS_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
  } sos_bus_s;
endpackage

// ===== verilog/sos_stab_counter.sv
// Oscillation stabilization counter with thermometer status output.
// Assumes the oscillator start indication is synchronous to ref_clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "sos_map.svh"
module sos_stab_counter
  import sos_pkg::*;
#(
  parameter int STAGES = `SOS_STAGES,
  parameter int CNT_W  = `SOS_CNT_W,
  parameter int BASE   = `SOS_BASE_LOG2
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              clear_i,
  input  wire logic              count_en_i,
  input  wire logic [`SOS_SEL_W-1:0] sel_i,
  output logic [STAGES-1:0]      status_o,
  output logic                   done_o
);
  // Refused at elaboration: longest stage must fit the counter
  if (BASE + 2 * (STAGES - 1) >= CNT_W) begin : g_width_chk
    $error("sos_stab_counter: counter too narrow for stages");
  end
  if (STAGES < 1 || STAGES > (1 << `SOS_SEL_W)) begin : g_stage_chk
    $error("sos_stab_counter: stage count does not fit select width");
  end

  function automatic logic [CNT_W-1:0] stage_limit(input int k);
    stage_limit = CNT_W'(1) << (BASE + 2 * k);
  endfunction

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] limit;
  int               sel_idx;

  always_comb begin
    sel_idx = (int'(sel_i) >= STAGES) ? STAGES - 1 : int'(sel_i);
    limit   = stage_limit(sel_idx);
  end

  assign done_o = (cnt_reg >= limit);

  // Counts only while running oscillator is present; stops at selected wait
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (clear_i) begin // R12
      cnt_reg <= '0;
    end else if (count_en_i && !done_o) begin // R02 R04
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else if (clear_i) begin // R12
      status_o <= '0;
    end else begin
      for (int k = 0; k < STAGES; k++) begin
        // Sticky; never beyond the selected stage
        if (k <= sel_idx && cnt_reg >= stage_limit(k)) // R01 R02
          status_o[k] <= 1'b1;
      end
    end
  end

  beyond_sel_a: assert property ( // R02
    @(posedge ref_clk_i) disable iff (rst_i)
    (sel_idx < STAGES - 1) |=> !$rose(status_o[STAGES-1]))
    else $error("status bit set beyond selected wait");

  count_hold_a: assert property ( // R04
    @(posedge ref_clk_i) disable iff (rst_i)
    (!count_en_i && !clear_i) |=> $stable(cnt_reg))
    else $error("counter moved before oscillation start");
endmodule // sos_stab_counter
`default_nettype wire

// ===== verilog/sos_standby_ctrl.sv
// Standby control: stop/halt entry, interrupt release, stabilization wait.
// Assumes the CPU core issues one-cycle stop and halt requests.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "sos_map.svh"
module sos_standby_ctrl
  import sos_pkg::*;
#(
  parameter int STAGES = `SOS_STAGES
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic [`SOS_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic [7:0]                  rdata_o,
  input  wire logic                   stop_req_i,
  input  wire logic                   halt_req_i,
  input  wire logic                   irq_pending_i,
  input  wire logic                   osc_started_i,
  output logic                        cpu_clk_en_o,
  output logic                        osc_run_o,
  output logic                        stop_mode_o,
  output logic                        halt_mode_o
);
  // Refused at elaboration: status must fit one 8-bit read
  if (STAGES < 1 || STAGES > 8) begin : g_stage_chk
    $error("sos_standby_ctrl: STAGES must be 1..8");
  end

  ////////////////////////////////////////////////////////////////////////
  sos_bus_s                bus;
  sos_state_e              state_reg;
  sos_state_e              state_next;
  logic [`SOS_SEL_W-1:0]   stab_time_select_reg;
  logic [STAGES-1:0]       stab_status_reg;
  logic                    stab_done;
  logic                    cnt_clear;
  logic                    cnt_en;
  logic                    osc_run_reg;

  assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stab_time_select_reg <= `SOS_SEL_RESET;
    end else if (bus.wr && bus.addr == `SOS_ADDR_SELECT) begin
      // Software must not write during a crystal wait
      stab_time_select_reg <= bus.wdata[`SOS_SEL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `SOS_ADDR_STATUS:  rdata_o <= 8'(stab_status_reg);
        `SOS_ADDR_SELECT:  rdata_o <= 8'(stab_time_select_reg);
        `SOS_ADDR_CONTROL: rdata_o <= {6'h00, halt_mode_o, stop_mode_o};
        default:           rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SOS_RUN: begin
        // Pending interrupt at stop: fall back to halt, still wait out
        if (stop_req_i && irq_pending_i) state_next = SOS_WAIT; // R07 R08
        else if (stop_req_i) state_next = SOS_STOP;
        else if (halt_req_i && !irq_pending_i) state_next = SOS_HALT; // R07
      end
      SOS_HALT: if (irq_pending_i) state_next = SOS_RUN; // R07
      SOS_STOP: if (irq_pending_i) state_next = SOS_WAIT; // R07
      SOS_WAIT: if (stab_done) state_next = SOS_RUN; // R08
      default:  state_next = SOS_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) state_reg <= SOS_RUN;
    else state_reg <= state_next;
  end

  // Oscillator off only in real stop; restart on release
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) osc_run_reg <= 1'b1;
    else osc_run_reg <= (state_next != SOS_STOP);
  end

  assign cnt_clear = (state_reg == SOS_RUN) && stop_req_i; // R12
  assign cnt_en    = (state_reg == SOS_WAIT) && osc_started_i; // R04

  sos_stab_counter #(
    .STAGES (STAGES)
  ) u_counter (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .clear_i    (cnt_clear),
    .count_en_i (cnt_en),
    .sel_i      (stab_time_select_reg),
    .status_o   (stab_status_reg),
    .done_o     (stab_done)
  );

  assign cpu_clk_en_o = (state_reg == SOS_RUN);
  assign osc_run_o    = osc_run_reg;
  assign stop_mode_o  = (state_reg == SOS_STOP);
  assign halt_mode_o  = (state_reg == SOS_HALT) || (state_reg == SOS_WAIT);

  ////////////////////////////////////////////////////////////////////////
  sequence stop_with_irq;
    (state_reg == SOS_RUN) && stop_req_i && irq_pending_i;
  endsequence

  sequence halt_with_irq;
    (state_reg == SOS_RUN) && !stop_req_i && halt_req_i && irq_pending_i;
  endsequence

  stop_to_halt_a: assert property ( // R08
    @(posedge ref_clk_i) disable iff (rst_i)
    stop_with_irq |=> !stop_mode_o && halt_mode_o)
    else $error("stop not turned into halt on pending interrupt");

  stop_cancel_a: assert property ( // R07
    @(posedge ref_clk_i) disable iff (rst_i)
    (stop_mode_o && irq_pending_i) |=> !stop_mode_o)
    else $error("stop not cancelled by pending interrupt");

  halt_cancel_a: assert property ( // R07
    @(posedge ref_clk_i) disable iff (rst_i)
    ((state_reg == SOS_HALT) && irq_pending_i) |=> cpu_clk_en_o)
    else $error("halt not cancelled by pending interrupt");

  halt_refuse_a: assert property ( // R07
    @(posedge ref_clk_i) disable iff (rst_i)
    halt_with_irq |=> cpu_clk_en_o && !halt_mode_o)
    else $error("halt entered with interrupt pending");

  resume_wait_a: assert property ( // R08
    @(posedge ref_clk_i) disable iff (rst_i)
    ((state_reg == SOS_WAIT) && !stab_done) |=> !cpu_clk_en_o)
    else $error("cpu resumed before wait elapsed");

  resume_done_a: assert property ( // R08
    @(posedge ref_clk_i) disable iff (rst_i)
    ((state_reg == SOS_WAIT) && stab_done) |=> cpu_clk_en_o)
    else $error("cpu not resumed once wait elapsed");

  stop_clear_a: assert property ( // R12
    @(posedge ref_clk_i) disable iff (rst_i)
    ((state_reg == SOS_RUN) && stop_req_i) |=> stab_status_reg == '0)
    else $error("status not cleared on stop entry");

  status_sticky_a: assert property ( // R01
    @(posedge ref_clk_i) disable iff (rst_i)
    !cnt_clear |=>
      (stab_status_reg & $past(stab_status_reg)) == $past(stab_status_reg))
    else $error("status bit dropped");

  status_order_a: assert property ( // R01
    @(posedge ref_clk_i) disable iff (rst_i)
    stab_status_reg[STAGES-1] |-> stab_status_reg[0])
    else $error("status bits set out of order");

  // Select writes excluded: moving the wait mid-count is refused by software
  no_osc_a: assert property ( // R04
    @(posedge ref_clk_i) disable iff (rst_i)
    ((state_reg == SOS_WAIT) && !osc_started_i && !stab_done &&
      !(wr_i && addr_i == `SOS_ADDR_SELECT)) |=> !stab_done)
    else $error("wait advanced without oscillation");

  osc_off_a: assert property ( // R04
    @(posedge ref_clk_i) disable iff (rst_i)
    stop_mode_o |-> !osc_run_o)
    else $error("oscillator left running in stop");
endmodule // sos_standby_ctrl
`default_nettype wire

// ===== verif/sos_cpu_model.sv
// CPU core model: issues stop and halt, drives interrupt and oscillator start.
// Assumes one calling process; oscillator start follows the oscillator enable while osc_ok is set.
`timescale 1ns/1ns
`default_nettype none
module sos_cpu_model (
  input  wire logic ref_clk_i,
  input  wire logic osc_run_i,
  output logic      stop_req_o,
  output logic      halt_req_o,
  output logic      irq_pending_o,
  output logic      osc_started_o
);
  logic osc_ok = 1'b1;
  initial begin
    stop_req_o    = 1'b0;
    halt_req_o    = 1'b0;
    irq_pending_o = 1'b0;
  end
  // A stopped oscillator reports no start until re-enabled and allowed
  always @(posedge ref_clk_i) osc_started_o <= osc_run_i & osc_ok;
  // Converter and peripherals idle, main clock selected before entry
  task automatic issue(input logic stop);
    @(posedge ref_clk_i);
    stop_req_o <= stop;
    halt_req_o <= !stop;
    @(posedge ref_clk_i);
    stop_req_o <= 1'b0;
    halt_req_o <= 1'b0;
  endtask
  task automatic set_in(input logic irq, input logic ok);
    @(posedge ref_clk_i);
    irq_pending_o <= irq;
    osc_ok        <= ok;
  endtask
endmodule // sos_cpu_model
`default_nettype wire

// ===== verif/standby_osc_stabilization_tb_top.sv
// Testbench for the standby control and stabilization counter.
// Assumes the CPU model above; register bus driven here.
`timescale 1ns/1ns
`default_nettype none
module standby_osc_stabilization_tb_top;
  import sos_pkg::*;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic stop_req, halt_req, irq, osc_st, clk_en, osc_run, stop_m, halt_m;
  int errors = 0, checked = 0, cyc = 0, n;
  initial forever #5 ref_clk_i = ~ref_clk_i;
  sos_standby_ctrl sos_standby_ctrl_inst (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .stop_req_i(stop_req), .halt_req_i(halt_req),
    .irq_pending_i(irq), .osc_started_i(osc_st), .cpu_clk_en_o(clk_en),
    .osc_run_o(osc_run), .stop_mode_o(stop_m), .halt_mode_o(halt_m));
  sos_cpu_model sos_cpu_model_inst (.ref_clk_i(ref_clk_i),
    .osc_run_i(osc_run), .stop_req_o(stop_req), .halt_req_o(halt_req),
    .irq_pending_o(irq), .osc_started_o(osc_st));
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic check(input string nm, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_rng(input string nm, input int lo, hi, g);
    checked++;
    if (g < lo || g > hi) begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_run();
    n = 0;
    while (clk_en !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic t_regs();
    bus(0, 4'h1, 0); check("select", 8'h04, v);
    tick(1);
    check("rdata_idle", 8'h00, rdata);
    bus(1, 4'h1, 8'hff);
    bus(0, 4'h1, 0);
    check("select", 8'h07, v);
    bus(1, 4'h0, 8'hff); bus(0, 4'h0, 0); check("status", 8'h00, v);
    bus(1, 4'hf, 8'hff); bus(0, 4'hf, 0); check("unmapped", 8'h00, v);
    bus(1, 4'h2, 8'h03);
    bus(0, 4'h2, 0); check("control", 8'h00, v);
  endtask
  task automatic t_stop_release();
    bus(1, 4'h1, 8'h00);
    sos_cpu_model_inst.set_in(0, 0);
    sos_cpu_model_inst.issue(1);
    tick(1); check("stop_mode", 8'h01, {7'h0, stop_m});
    check("osc_run", 8'h00, {7'h0, osc_run});
    bus(0, 4'h0, 0); check("status", 8'h00, v);
    tick(40); sos_cpu_model_inst.set_in(1, 0); tick(2);
    check("halt_mode", 8'h01, {7'h0, halt_m});
    check("osc_run", 8'h01, {7'h0, osc_run});
    bus(0, 4'h2, 0); check("control", 8'h02, v);
    tick(100); check("cpu_clk_en", 8'h00, {7'h0, clk_en});
    sos_cpu_model_inst.set_in(1, 1);
    wait_run(); check_rng("wait", 256, 260, n);
    bus(0, 4'h0, 0); check("status", 8'h01, v);
    sos_cpu_model_inst.set_in(0, 1);
  endtask
  task automatic t_stop_irq_entry();
    bus(1, 4'h1, 8'h01);
    sos_cpu_model_inst.set_in(1, 1);
    sos_cpu_model_inst.issue(1);
    tick(1); check("stop_mode", 8'h00, {7'h0, stop_m});
    check("halt_mode", 8'h01, {7'h0, halt_m});
    tick(500); bus(0, 4'h0, 0); check("status", 8'h01, v);
    wait_run(); check_rng("wait", 1020, 1030, n + 505);
    bus(0, 4'h0, 0); check("status", 8'h03, v);
    sos_cpu_model_inst.set_in(0, 1);
  endtask
  task automatic t_halt();
    sos_cpu_model_inst.set_in(1, 1);
    sos_cpu_model_inst.issue(0);
    tick(1); check("halt_ignored", 8'h00, {7'h0, halt_m});
    sos_cpu_model_inst.set_in(0, 1);
    sos_cpu_model_inst.issue(0);
    tick(1); check("halt_mode", 8'h01, {7'h0, halt_m});
    sos_cpu_model_inst.set_in(1, 1);
    tick(3); check("cpu_clk_en", 8'h01, {7'h0, clk_en});
    sos_cpu_model_inst.set_in(0, 1);
  endtask
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_stop_release();
    t_stop_irq_entry();
    t_halt();
    stop_test();
  end
endmodule // standby_osc_stabilization_tb_top
`default_nettype wire
